/* File: logic/dpa_pkg.sv */
// constants for the host-side port controller of the two-port memory
// assumes a 250 MHz system clock; timing figures are in ns
package dpa_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W      = 13;                 // 8K locations
    localparam int DATA_W      = 8;                  // byte wide
    localparam int TOKEN_CNT   = 8;                  // token latches
    localparam int TOKEN_IDX_W = 3;                  // latch select bits
    localparam int CNT_W       = 8;                  // wait counter width

    // ------------------------------------------------------------
    // timing, in ns, and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_ACCESS_NS   = 55;               // array access delay
    localparam int T_FLOW_NS     = 30;               // port-to-port flow-through
    localparam int T_WPULSE_NS   = 20;               // write strobe low time
    localparam int T_SETTLE_NS   = 15;               // contention flag settle
    localparam int T_GAP_NS      = 20;               // strobe-high gap after access

    // least time rounded up to whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // two extra cycles cover the data-bus synchroniser
    localparam logic [CNT_W-1:0] READ_CYC   = CNT_W'(cyc_min(T_ACCESS_NS + T_FLOW_NS) + 2);
    localparam logic [CNT_W-1:0] WPULSE_CYC = CNT_W'(cyc_min(T_WPULSE_NS));
    localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(cyc_min(T_SETTLE_NS));
    localparam logic [CNT_W-1:0] GAP_CYC    = CNT_W'(cyc_min(T_GAP_NS));

    // ------------------------------------------------------------
    // reset values and commands
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST     = 13'h0000;
    localparam logic [DATA_W-1:0] TOKEN_FREE   = 8'hff;  // release / free value
    localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
    localparam logic [TOKEN_IDX_W-1:0] TOK_LAST = 3'h7;

    typedef enum logic [1:0] {
        DPA_OP_READ      = 2'h0,
        DPA_OP_WRITE     = 2'h1,
        DPA_OP_TOK_READ  = 2'h2,
        DPA_OP_TOK_WRITE = 2'h3
    } dpa_op_t;

    typedef enum logic [2:0] {
        DPA_ST_IDLE    = 3'h0,
        DPA_ST_SETUP   = 3'h1,
        DPA_ST_ACTIVE  = 3'h3,
        DPA_ST_RECOVER = 3'h2
    } dpa_state_t;

endpackage

/* File: logic/dpa_host.sv */
// host controller driving one port of the two-port memory by its pins
// assumes the pins are asynchronous to clk_sys_in; the bench resolves the data wire
`timescale 1ns/1ps

module dpa_host (
    input  wire logic                        clk_sys_in,        // system clock
    input  wire logic                        sys_rst_in,        // sync reset, high
    input  wire logic                        role_master_in,    // strap value for role pin
    input  wire logic                        cmd_valid_in,      // command offered
    input  wire logic [1:0]                  cmd_op_in,         // dpa_op_t code
    input  wire logic [dpa_pkg::ADDR_W-1:0]  cmd_addr_in,       // address or token index
    input  wire logic [dpa_pkg::DATA_W-1:0]  cmd_wdata_in,      // write data
    output logic                             cmd_ready_out,     // command taken when high
    output logic                             rsp_valid_out,     // one-cycle done pulse
    output logic [dpa_pkg::DATA_W-1:0]       rsp_data_out,      // read result
    output logic                             contention_out,    // one-cycle retry pulse
    output logic                             mbox_pending_out,  // mailbox flag seen low
    output logic                             init_busy_out,     // token start-up running
    output logic [dpa_pkg::ADDR_W-1:0]       addr_out,          // address pins
    output logic                             array_select_n_out,       // array select
    output logic                             token_latch_select_n_out, // token select
    output logic                             output_drive_n_out,       // output drive
    output logic                             write_strobe_n_out,       // write strobe
    output logic                             role_select_out,          // master/slave pin
    input  wire logic [dpa_pkg::DATA_W-1:0]  data_in,           // data pins sensed
    output logic [dpa_pkg::DATA_W-1:0]       data_out,          // data pins driven
    output logic                             data_oe_out,       // high while driving
    input  wire logic                        contention_flag_n_in, // contention flag pin
    input  wire logic                        mailbox_flag_n_in     // mailbox flag pin
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [dpa_pkg::DATA_W-1:0] data_s1_reg;
    logic [dpa_pkg::DATA_W-1:0] data_s2_reg;
    logic                       busy_s1_reg;
    logic                       busy_s2_reg;
    logic                       mbox_s1_reg;
    logic                       mbox_s2_reg;

    // two flops on every asynchronous pin
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            data_s1_reg <= dpa_pkg::DATA_RST;
            data_s2_reg <= dpa_pkg::DATA_RST;
            busy_s1_reg <= 1'b1;
            busy_s2_reg <= 1'b1;
            mbox_s1_reg <= 1'b1;
            mbox_s2_reg <= 1'b1;
        end else begin
            data_s1_reg <= data_in;
            data_s2_reg <= data_s1_reg;
            busy_s1_reg <= contention_flag_n_in;
            busy_s2_reg <= busy_s1_reg;
            mbox_s1_reg <= mailbox_flag_n_in;
            mbox_s2_reg <= mbox_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    dpa_pkg::dpa_state_t             state_reg,   state_next;
    logic [dpa_pkg::CNT_W-1:0]       cnt_reg,     cnt_next;
    logic [1:0]                      op_reg,      op_next;
    logic                            init_reg,    init_next;
    logic [dpa_pkg::TOKEN_IDX_W-1:0] tok_reg,     tok_next;
    logic [dpa_pkg::ADDR_W-1:0]      addr_reg,    addr_next;
    logic [dpa_pkg::DATA_W-1:0]      dout_reg,    dout_next;
    logic                            doe_reg,     doe_next;
    logic                            ce_n_reg,    ce_n_next;
    logic                            sem_n_reg,   sem_n_next;
    logic                            oe_n_reg,    oe_n_next;
    logic                            we_n_reg,    we_n_next;
    logic [dpa_pkg::DATA_W-1:0]      rdata_reg,   rdata_next;
    logic                            rsp_reg,     rsp_next;
    logic                            cont_reg,    cont_next;
    logic                            ready_reg,   ready_next;
    logic                            mbox_reg;
    logic                            role_reg;
    logic                            is_token;
    logic                            is_write;

    assign is_token = op_reg[1];
    assign is_write = op_reg[0];

    // next-state and pin values
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        op_next    = op_reg;
        init_next  = init_reg;
        tok_next   = tok_reg;
        addr_next  = addr_reg;
        dout_next  = dout_reg;
        doe_next   = doe_reg;
        ce_n_next  = ce_n_reg;
        sem_n_next = sem_n_reg;
        oe_n_next  = oe_n_reg;
        we_n_next  = we_n_reg;
        rdata_next = rdata_reg;
        rsp_next   = 1'b0;
        cont_next  = 1'b0;
        case (state_reg)
            dpa_pkg::DPA_ST_IDLE: begin
                if (init_reg) begin
                    op_next    = dpa_pkg::DPA_OP_TOK_WRITE;
                    addr_next  = {{(dpa_pkg::ADDR_W-dpa_pkg::TOKEN_IDX_W){1'b0}}, tok_reg};
                    dout_next  = dpa_pkg::TOKEN_FREE;
                    cnt_next   = dpa_pkg::SETTLE_CYC;
                    state_next = dpa_pkg::DPA_ST_SETUP;
                end else if (cmd_valid_in && ready_reg) begin
                    op_next    = cmd_op_in;
                    addr_next  = cmd_addr_in;
                    dout_next  = cmd_wdata_in;
                    cnt_next   = dpa_pkg::SETTLE_CYC;
                    state_next = dpa_pkg::DPA_ST_SETUP;
                end
            end
            dpa_pkg::DPA_ST_SETUP: begin
                // one select only: array or token, never both
                ce_n_next  = is_token;
                sem_n_next = ~is_token;
                doe_next   = is_write;
                if (cnt_reg > 1) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (is_token || busy_s2_reg) begin
                    we_n_next  = ~is_write;
                    oe_n_next  = is_write;
                    cnt_next   = is_write ? dpa_pkg::WPULSE_CYC : dpa_pkg::READ_CYC;
                    state_next = dpa_pkg::DPA_ST_ACTIVE;
                end
            end
            dpa_pkg::DPA_ST_ACTIVE: begin
                if (!is_token && !busy_s2_reg) begin
                    // lost arbitration: drop strobes and retry the access
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    cont_next  = 1'b1;
                    cnt_next   = dpa_pkg::SETTLE_CYC;
                    state_next = dpa_pkg::DPA_ST_SETUP;
                end else if (cnt_reg > 1) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    // strobe rises while data still driven
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    if (!is_write) begin
                        // token value sits on bit 0; copied to all lines
                        rdata_next = is_token ? {dpa_pkg::DATA_W{data_s2_reg[0]}}
                                              : data_s2_reg;
                    end
                    cnt_next   = dpa_pkg::GAP_CYC;
                    state_next = dpa_pkg::DPA_ST_RECOVER;
                end
            end
            dpa_pkg::DPA_ST_RECOVER: begin
                // both selects high powers the port down
                ce_n_next  = 1'b1;
                sem_n_next = 1'b1;
                doe_next   = 1'b0;
                if (cnt_reg > 1) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    state_next = dpa_pkg::DPA_ST_IDLE;
                    if (init_reg) begin
                        tok_next  = tok_reg + 1'b1;
                        init_next = (tok_reg != dpa_pkg::TOK_LAST);
                    end else begin
                        rsp_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = dpa_pkg::DPA_ST_IDLE;
            end
        endcase
        ready_next = (state_next == dpa_pkg::DPA_ST_IDLE) && !init_next && !rsp_next;
    end

    // sequencer registers
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_reg <= dpa_pkg::DPA_ST_IDLE;
            cnt_reg   <= '0;
            op_reg    <= dpa_pkg::DPA_OP_READ;
            init_reg  <= 1'b1;
            tok_reg   <= '0;
            addr_reg  <= dpa_pkg::ADDR_RST;
            dout_reg  <= dpa_pkg::DATA_RST;
            doe_reg   <= 1'b0;
            ce_n_reg  <= 1'b1;
            sem_n_reg <= 1'b1;
            oe_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            rdata_reg <= dpa_pkg::DATA_RST;
            rsp_reg   <= 1'b0;
            cont_reg  <= 1'b0;
            ready_reg <= 1'b0;
            mbox_reg  <= 1'b0;
            role_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            op_reg    <= op_next;
            init_reg  <= init_next;
            tok_reg   <= tok_next;
            addr_reg  <= addr_next;
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            ce_n_reg  <= ce_n_next;
            sem_n_reg <= sem_n_next;
            oe_n_reg  <= oe_n_next;
            we_n_reg  <= we_n_next;
            rdata_reg <= rdata_next;
            rsp_reg   <= rsp_next;
            cont_reg  <= cont_next;
            ready_reg <= ready_next;
            mbox_reg  <= ~mbox_s2_reg;
            role_reg  <= role_master_in;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign cmd_ready_out            = ready_reg;
    assign rsp_valid_out            = rsp_reg;
    assign rsp_data_out             = rdata_reg;
    assign contention_out           = cont_reg;
    assign mbox_pending_out         = mbox_reg;
    assign init_busy_out            = init_reg;
    assign addr_out                 = addr_reg;
    assign array_select_n_out       = ce_n_reg;
    assign token_latch_select_n_out = sem_n_reg;
    assign output_drive_n_out       = oe_n_reg;
    assign write_strobe_n_out       = we_n_reg;
    assign role_select_out          = role_reg;
    assign data_out                 = dout_reg;
    assign data_oe_out              = doe_reg;

endmodule

/* File: tb/dpa_host_properties.sv */
// pin-level checker for the host port controller
// assumes it is bound into dpa_host and sees only its ports
`timescale 1ns/1ps

module dpa_host_properties (
    input wire logic                       clk_sys_in,               // clock
    input wire logic                       sys_rst_in,               // reset
    input wire logic                       role_master_in,           // role strap
    input wire logic                       cmd_ready_out,            // ready
    input wire logic                       rsp_valid_out,            // done pulse
    input wire logic                       array_select_n_out,       // array select
    input wire logic                       token_latch_select_n_out, // token select
    input wire logic                       output_drive_n_out,       // output drive
    input wire logic                       write_strobe_n_out,       // write strobe
    input wire logic [dpa_pkg::DATA_W-1:0] data_out,                 // driven data
    input wire logic                       data_oe_out,              // data enable
    input wire logic                       role_select_out,          // role pin
    input wire logic                       mailbox_flag_n_in,        // mailbox pin
    input wire logic                       mbox_pending_out          // mailbox seen
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // pins idle, strobe timing, role copy, done pulse and mailbox flag
    rst_idle_a: assert property (
        $fell(sys_rst_in) |-> array_select_n_out && token_latch_select_n_out && write_strobe_n_out
        && !data_oe_out && !cmd_ready_out) else $error("pins not idle after reset");
    sel_excl_a: assert property (
        array_select_n_out || token_latch_select_n_out) else $error("both selects low");
    strobe_data_a: assert property (
        !write_strobe_n_out |-> data_oe_out && output_drive_n_out) else $error("strobe without data");
    data_hold_a: assert property (
        $rose(write_strobe_n_out) |-> $stable(data_out) && data_oe_out) else $error("data moved at strobe end");
    read_float_a: assert property (
        !output_drive_n_out |-> !data_oe_out) else $error("driving during read");
    role_copy_a: assert property (
        !sys_rst_in ##1 !sys_rst_in |-> role_select_out == $past(role_master_in)) else $error("role pin wrong");
    rsp_pulse_a: assert property (
        rsp_valid_out |=> !rsp_valid_out && cmd_ready_out) else $error("done pulse not single");
    tok_pulse_a: assert property (
        $fell(write_strobe_n_out) && !token_latch_select_n_out |-> (!write_strobe_n_out)[*5]
        ##1 write_strobe_n_out) else $error("token strobe width wrong");
    tok_gap_a: assert property (
        $rose(token_latch_select_n_out) |-> token_latch_select_n_out[*6]) else $error("token gap short");
    mbox_seen_a: assert property (
        (!mailbox_flag_n_in)[*5] |-> mbox_pending_out) else $error("mailbox flag missed");
endmodule

bind dpa_host dpa_host_properties u_props (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .role_master_in(role_master_in),
    .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .array_select_n_out(array_select_n_out),
    .token_latch_select_n_out(token_latch_select_n_out), .output_drive_n_out(output_drive_n_out),
    .write_strobe_n_out(write_strobe_n_out), .data_out(data_out), .data_oe_out(data_oe_out),
    .role_select_out(role_select_out), .mailbox_flag_n_in(mailbox_flag_n_in),
    .mbox_pending_out(mbox_pending_out));

/* File: tb/dpa_dev_model.sv */
// behavioural two-port memory seen from its left port
// assumes the bench plays the right-side processor through the tasks below
`timescale 1ns/1ps

module dpa_dev_model (
    input  wire logic [dpa_pkg::ADDR_W-1:0] addr_in,                 // address pins
    input  wire logic                       array_select_n_in,       // array select
    input  wire logic                       token_latch_select_n_in, // token select
    input  wire logic                       output_drive_n_in,       // output drive
    input  wire logic                       write_strobe_n_in,       // write strobe
    input  wire logic [dpa_pkg::DATA_W-1:0] bus_in,                  // resolved data wire
    input  wire logic                       hold_in,                 // right side holds location
    output logic      [dpa_pkg::DATA_W-1:0] dq_out,                  // data driven or junk
    output logic                            contention_flag_n_out,   // contention flag
    output logic                            mailbox_flag_n_out       // left mailbox flag
);
    logic [7:0] mem [0:8191];
    logic [1:0] owner [8] = '{default: 2'h1}; // junk at power-up: left owns
    logic [1:0] pend [8] = '{default: 2'h0};  // bit0 left, bit1 right
    logic [7:0] last = 8'h00;
    logic       mbox_n = 1'b1;
    logic       rflag_n = 1'b1;               // right side mailbox flag
    logic       drv;
    logic [7:0] val;

    // token write by side 1 (left) or 2 (right); same-step requests settle in call order
    task automatic tokw(input int side, input int i, input logic v);
        if (!v) begin
            if (owner[i] == 2'h0) owner[i] = 2'(side);
            else if (owner[i] != 2'(side)) pend[i][side-1] = 1'b1;
        end else begin
            pend[i][side-1] = 1'b0;
            if (owner[i] == 2'(side)) begin
                owner[i] = pend[i][2-side] ? 2'(3-side) : 2'h0;
                pend[i] = 2'h0;
            end
        end
    endtask

    // right side writes the left mailbox word
    task automatic rmbox(input logic [7:0] d);
        mem[13'h1ffe] = d;
        mbox_n = 1'b0;
    endtask

    // read decode; a released wire shows the inverse of its last value
    assign drv = !output_drive_n_in && write_strobe_n_in && (array_select_n_in != token_latch_select_n_in);
    assign val = !token_latch_select_n_in ? {8{owner[addr_in[2:0]] != 2'h1}} : mem[addr_in];
    always @(drv or val) if (drv) last = val;
    assign dq_out = drv ? val : ~last;

    // writes land on the rising strobe
    always @(posedge write_strobe_n_in) begin
        // a write from the losing side of a contention never lands
        if (!array_select_n_in && !hold_in) mem[addr_in] = bus_in;
        if (!array_select_n_in && !hold_in && addr_in == 13'h1fff) rflag_n = 1'b0;
        if (!token_latch_select_n_in) tokw(1, int'(addr_in[2:0]), bus_in[0]);
    end
    always @(negedge output_drive_n_in) if (!array_select_n_in && addr_in == 13'h1ffe) mbox_n = 1'b1;
    assign contention_flag_n_out = ~hold_in;
    assign mailbox_flag_n_out = mbox_n;
endmodule

/* File: tb/dpa_host_tb_top.sv */
// self-checking bench for the host port controller
// assumes dpa_dev_model stands on the pins; the bench plays the right side
`timescale 1ns/1ps

module dpa_host_tb_top;
    logic                         clk_sys_in = 1'b0;
    logic                         sys_rst_in = 1'b1;
    logic                         rm = 1'b1;
    logic                         cv = 1'b0;
    logic [1:0]                   cop = 2'h0;
    logic [dpa_pkg::ADDR_W-1:0]   ca = 13'h0000;
    logic [dpa_pkg::DATA_W-1:0]   cd = 8'h00;
    logic                         hold = 1'b0;
    logic                         rdy, rv, cont, mbox, asn, tsn, odn, wsn, oe, busy_n, mbox_n, ib, rs;
    logic [dpa_pkg::ADDR_W-1:0]   pa, a;
    logic [dpa_pkg::DATA_W-1:0]   rd, dout, mdq, bus, q, d;
    logic [7:0]                   mirror [int];
    int                           n_fail = 0, n_tests = 0, seed = 96388, n_cont = 0, i;

    always #2 clk_sys_in = ~clk_sys_in;
    assign bus = oe ? dout : mdq;
    always @(posedge clk_sys_in) if (cont === 1'b1) n_cont++;

    dpa_host DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .role_master_in(rm), .cmd_valid_in(cv),
        .cmd_op_in(cop), .cmd_addr_in(ca), .cmd_wdata_in(cd), .cmd_ready_out(rdy), .rsp_valid_out(rv),
        .rsp_data_out(rd), .contention_out(cont), .mbox_pending_out(mbox), .init_busy_out(ib), .addr_out(pa),
        .array_select_n_out(asn), .token_latch_select_n_out(tsn), .output_drive_n_out(odn),
        .write_strobe_n_out(wsn), .role_select_out(rs), .data_in(bus), .data_out(dout), .data_oe_out(oe),
        .contention_flag_n_in(busy_n), .mailbox_flag_n_in(mbox_n));
    dpa_dev_model u_dev (.addr_in(pa), .array_select_n_in(asn), .token_latch_select_n_in(tsn),
        .output_drive_n_in(odn), .write_strobe_n_in(wsn), .bus_in(bus), .hold_in(hold), .dq_out(mdq),
        .contention_flag_n_out(busy_n), .mailbox_flag_n_out(mbox_n));

    // expected token read: all lines low when this port owns it
    function automatic logic [7:0] tok_exp(input bit mine);
        return mine ? 8'h00 : 8'hff;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one command: offer when ready, drop after the taking edge, wait for done
    task automatic cmd(input logic [1:0] op, input logic [12:0] ad, input logic [7:0] wd, output logic [7:0] rq);
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 2000) begin @(posedge clk_sys_in); #1; k++; end
        if (rdy !== 1'b1) chk({7'h00, rdy}, 8'h01);
        cv = 1'b1; cop = op; ca = ad; cd = wd;
        @(posedge clk_sys_in); #1;
        cv = 1'b0;
        k = 0;
        while (rv !== 1'b1 && k < 2000) begin @(posedge clk_sys_in); #1; k++; end
        if (rv !== 1'b1) chk({7'h00, rv}, 8'h01);
        rq = rd;
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #40000;
        n_fail++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge clk_sys_in);
        #1 sys_rst_in = 1'b0;
        @(posedge clk_sys_in);
        #1 chk({7'h00, ib}, 8'h01);
        // random array traffic plus addresses 0 and 1ffd, just below the mailbox words, back to back
        for (i = 0; i < 10; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1ffd : 13'($random(seed)) & 13'h1ffd;
            d = 8'($random(seed));
            cmd(dpa_pkg::DPA_OP_WRITE, a, d, q);
            mirror[int'(a)] = d;
        end
        foreach (mirror[k]) begin cmd(dpa_pkg::DPA_OP_READ, 13'(k), 8'h00, q); chk(q, mirror[k]); end
        chk({7'h00, ib}, 8'h00);
        // token walk over every latch, random role strap meanwhile
        rm = 1'($random(seed));
        for (i = 0; i < 8; i++) begin
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(0));
            cmd(dpa_pkg::DPA_OP_TOK_WRITE, {10'($random(seed)), 3'(i)}, 8'hfe, q);
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(1));
            u_dev.tokw(2, i, 1'b0);
            cmd(dpa_pkg::DPA_OP_TOK_WRITE, 13'(i), 8'h01, q);
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(0));
            cmd(dpa_pkg::DPA_OP_TOK_WRITE, 13'(i), 8'h00, q);
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(0));
            u_dev.tokw(2, i, 1'b1);
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(1));
            cmd(dpa_pkg::DPA_OP_TOK_WRITE, 13'(i), 8'hff, q);
            cmd(dpa_pkg::DPA_OP_TOK_READ, 13'(i), 8'h00, q); chk(q, tok_exp(0));
        end
        chk({7'h00, rs}, {7'h00, rm});
        rm = 1'b1;
        // mailbox raised by the right side, cleared by reading its word
        u_dev.rmbox(8'h5a);
        repeat (8) @(posedge clk_sys_in);
        #1 chk({7'h00, mbox}, 8'h01);
        cmd(dpa_pkg::DPA_OP_READ, 13'h1ffe, 8'h00, q); chk(q, 8'h5a);
        repeat (8) @(posedge clk_sys_in);
        #1 chk({7'h00, mbox}, 8'h00);
        // left write of the top word raises the right side's flag
        cmd(dpa_pkg::DPA_OP_WRITE, 13'h1fff, 8'ha5, q);
        chk({7'h00, u_dev.rflag_n}, 8'h00);
        // contention flag falls in mid-strobe: write retried and still lands
        fork
            cmd(dpa_pkg::DPA_OP_WRITE, 13'h0155, 8'h3c, q);
            begin repeat (7) @(posedge clk_sys_in); #1 hold = 1'b1; repeat (6) @(posedge clk_sys_in); #1 hold = 1'b0; end
        join
        cmd(dpa_pkg::DPA_OP_READ, 13'h0155, 8'h00, q); chk(q, 8'h3c);
        chk({7'h00, n_cont > 0}, 8'h01);
        give_verdict;
    end
endmodule
